// ### hw/hibernate_power_rtc_controller.sv
// Hibernation power controller with RTC, match wake and retained memory.
// Assumes an APB master on clk and a battery-backed supply for this logic.
// How it works
// (RULE1) Entering sleep drives regulator off pin low
// (RULE2) Wake pin or match releases regulator off
// (RULE3) Software spaces slow-domain writes and reads
// (RULE4) Back-to-back reads accepted without wait states
// (RULE5) Crystal path divided by 128 for reference
// (RULE6) Enable bit gates source; select picks path
// (RULE7) Software waits crystal settling after enable
// (RULE8) Detect enabled low battery sets status flag
// (RULE9) Abort option refuses sleep on low battery
// (RULE10) 32-bit counter increments once per second
// (RULE11) Predivider uses trim one second in 64
// (RULE12) Higher trim slows, lower trim speeds RTC
// (RULE13) Two match registers wake or interrupt
// (RULE14) Counter advances only with run enable set
// (RULE15) Load register write sets counter immediately
// (RULE16) Sixty-four retained words readable and writable
// (RULE17) Sleep request bit starts hibernation sequence
// (RULE18) Software configures a wake source before sleeping
// (RULE19) Separate pin and match wake enables
// (RULE20) Wake looks like power-on; raw status kept
// (RULE21) Events ORed into one interrupt request
// (RULE22) Mask selects events; write one clears
// (RULE23) Match flagged on tick reaching match value
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module hibernate_power_rtc_controller
    import hib_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock source pins
    input  wire logic        osc_clk_in,
    input  wire logic        xtal_clk_in,
    // Power and wake pins
    input  wire logic        wake_n,
    input  wire logic        battery_low_in,
    output logic             regulator_off_n,
    // Interrupt request
    output logic             irq
);
    // Aligned word inside the retained window
    function automatic logic is_mem(input logic [11:0] a);
        is_mem = (a >= ADDR_MEM_FIRST) && (a <= ADDR_MEM_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [MEM_IDX_W-1:0] mem_index(input logic [11:0] a);
        logic [11:0] off;
        off = a - ADDR_MEM_FIRST;
        mem_index = off[MEM_IDX_W+1:2];
    endfunction

    // Synchronised pins
    logic osc_s;
    logic xtal_s;
    logic wake_n_s;
    logic batt_low_s;

    pin_sync #(.RESET_VALUE(1'b0)) u_sync_osc (
        .clk   (clk),
        .reset (reset),
        .pin   (osc_clk_in),
        .level (osc_s)
    );
    pin_sync #(.RESET_VALUE(1'b0)) u_sync_xtal (
        .clk   (clk),
        .reset (reset),
        .pin   (xtal_clk_in),
        .level (xtal_s)
    );
    pin_sync #(.RESET_VALUE(1'b1)) u_sync_wake (
        .clk   (clk),
        .reset (reset),
        .pin   (wake_n),
        .level (wake_n_s)
    );
    pin_sync #(.RESET_VALUE(1'b0)) u_sync_batt (
        .clk   (clk),
        .reset (reset),
        .pin   (battery_low_in),
        .level (batt_low_s)
    );

    // Control bits
    logic        rtc_run_en_r;
    logic        sleep_request_r;
    logic        osc_source_select_r;
    logic        rtc_rouse_en_r;
    logic        pin_rouse_en_r;
    logic        battery_low_detect_en_r;
    logic        osc_enable_r;
    logic        abort_on_weak_battery_r;

    // Data registers
    logic [31:0]         rtc_count_r;
    logic [31:0]         rtc_match_a_r;
    logic [31:0]         rtc_match_b_r;
    logic [31:0]         rtc_load_value_r;
    logic [15:0]         rtc_predivider_trim_r;
    logic [EV_WIDTH-1:0] event_mask_r;
    logic [EV_WIDTH-1:0] raw_event_status_r;
    logic [31:0]         retained_memory_r [MEM_WORDS];

    // Bus and state
    logic [31:0]  prdata_r;
    logic         pslverr_r;
    logic         irq_r;
    logic         regulator_off_n_r;
    power_state_t state_r;
    power_state_t state_nxt;

    // Reference clock edge detection
    logic        osc_prev_r;
    logic        xtal_prev_r;
    logic [6:0]  xtal_div_r;
    logic        ref_tick;
    logic        sec_tick;
    logic [31:0] rtc_nxt;

    // Bus strobes
    logic wr_acc;
    logic rd_setup;
    logic ctl_wr;
    logic load_wr;
    logic clear_wr;

    // Event sources
    logic                hit_a;
    logic                hit_b;
    logic                pin_rise;
    logic                wake_pin_prev_r;
    logic [EV_WIDTH-1:0] ev_set;
    logic [EV_WIDTH-1:0] ev_clr;
    logic                rouse;
    logic                sleep_abort;
    logic [EV_WIDTH-1:0] masked;

    // Zero wait states
    assign pready   = 1'b1; // (RULE4)
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign ctl_wr   = wr_acc && (paddr == ADDR_CONTROL);
    assign load_wr  = wr_acc && (paddr == ADDR_LOAD);
    assign clear_wr = wr_acc && (paddr == ADDR_CLEAR);

    // Reference tick: oscillator edge, or crystal divided by 128
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_prev_r  <= 1'b0;
            xtal_prev_r <= 1'b0;
            xtal_div_r  <= '0;
        end else begin
            osc_prev_r  <= osc_s;
            xtal_prev_r <= xtal_s;
            if (!osc_enable_r || osc_source_select_r) begin
                xtal_div_r <= '0;
            end else if (xtal_s && !xtal_prev_r) begin
                xtal_div_r <= xtal_div_r + 7'h01; // (RULE5)
            end
        end
    end

    always_comb begin
        ref_tick = 1'b0;
        if (osc_enable_r) begin // (RULE6)
            if (osc_source_select_r) begin
                ref_tick = osc_s && !osc_prev_r;
            end else begin
                ref_tick = xtal_s && !xtal_prev_r && (xtal_div_r == XTAL_DIV_LAST); // (RULE5)
            end
        end
    end

    rtc_predivider u_prediv (
        .clk      (clk),
        .reset    (reset),
        .run      (rtc_run_en_r),
        .ref_tick (ref_tick),
        .trim     (rtc_predivider_trim_r),
        .sec_tick (sec_tick)
    );

    // Real-time counter
    assign rtc_nxt = rtc_count_r + 32'h00000001;

    always_ff @(posedge clk) begin
        if (reset) begin
            rtc_count_r <= '0;
        end else if (load_wr) begin
            rtc_count_r <= pwdata; // (RULE15)
        end else if (sec_tick && rtc_run_en_r) begin
            rtc_count_r <= rtc_nxt; // (RULE10) (RULE14)
        end
    end

    // Match only on a counting tick, never on a load
    assign hit_a = sec_tick && rtc_run_en_r && !load_wr && (rtc_nxt == rtc_match_a_r); // (RULE13) (RULE23)
    assign hit_b = sec_tick && rtc_run_en_r && !load_wr && (rtc_nxt == rtc_match_b_r); // (RULE13) (RULE23)

    // Data registers written over the bus
    always_ff @(posedge clk) begin
        if (reset) begin
            rtc_match_a_r         <= MATCH_RESET;
            rtc_match_b_r         <= MATCH_RESET;
            rtc_load_value_r      <= LOAD_RESET;
            rtc_predivider_trim_r <= TRIM_NOMINAL;
            event_mask_r          <= '0;
        end else if (wr_acc) begin
            unique case (paddr)
                ADDR_MATCH_A: begin
                    rtc_match_a_r <= pwdata;
                end
                ADDR_MATCH_B: begin
                    rtc_match_b_r <= pwdata;
                end
                ADDR_LOAD: begin
                    rtc_load_value_r <= pwdata;
                end
                ADDR_TRIM: begin
                    rtc_predivider_trim_r <= pwdata[15:0]; // (RULE12)
                end
                ADDR_MASK: begin
                    event_mask_r <= pwdata[EV_WIDTH-1:0]; // (RULE22)
                end
                default: begin
                end
            endcase
        end
    end

    // Reset stands for the battery power-up
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                retained_memory_r[i] <= '0;
            end
        end else if (wr_acc && is_mem(paddr)) begin
            retained_memory_r[mem_index(paddr)] <= pwdata; // (RULE16)
        end
    end

    // Control bits
    always_ff @(posedge clk) begin
        if (reset) begin
            rtc_run_en_r            <= 1'b0;
            osc_source_select_r     <= 1'b0;
            rtc_rouse_en_r          <= 1'b0;
            pin_rouse_en_r          <= 1'b0;
            battery_low_detect_en_r <= 1'b0;
            osc_enable_r            <= 1'b0;
            abort_on_weak_battery_r <= 1'b0;
        end else if (ctl_wr) begin
            rtc_run_en_r            <= pwdata[CTL_RTC_RUN]; // (RULE14)
            osc_source_select_r     <= pwdata[CTL_SRC_SEL]; // (RULE6)
            rtc_rouse_en_r          <= pwdata[CTL_RTC_ROUSE]; // (RULE19)
            pin_rouse_en_r          <= pwdata[CTL_PIN_ROUSE]; // (RULE19)
            battery_low_detect_en_r <= pwdata[CTL_BATT_DETECT];
            osc_enable_r            <= pwdata[CTL_OSC_ENABLE]; // (RULE6)
            abort_on_weak_battery_r <= pwdata[CTL_BATT_ABORT];
        end
    end

    // Request drops on wake or refusal
    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_request_r <= 1'b0;
        end else if (rouse || sleep_abort) begin
            sleep_request_r <= 1'b0;
        end else if (ctl_wr && state_r == ST_AWAKE) begin
            sleep_request_r <= pwdata[CTL_SLEEP_REQ]; // (RULE17)
        end
    end

    // Event sources
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_pin_prev_r <= 1'b0;
        end else begin
            wake_pin_prev_r <= !wake_n_s;
        end
    end

    assign pin_rise = !wake_n_s && !wake_pin_prev_r;

    always_comb begin
        ev_set              = '0;
        ev_set[EV_MATCH_A]  = hit_a;
        ev_set[EV_MATCH_B]  = hit_b;
        ev_set[EV_BATT_LOW] = battery_low_detect_en_r && batt_low_s; // (RULE8)
        ev_set[EV_PIN_WAKE] = pin_rise;
    end

    assign ev_clr = clear_wr ? pwdata[EV_WIDTH-1:0] : '0;

    // A new event in the clearing cycle stays pending
    always_ff @(posedge clk) begin
        if (reset) begin
            raw_event_status_r <= '0;
        end else begin
            raw_event_status_r <= (raw_event_status_r & ~ev_clr) | ev_set; // (RULE22) (RULE20)
        end
    end

    assign masked = raw_event_status_r & event_mask_r; // (RULE22)

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |masked; // (RULE21)
        end
    end

    // Power sequencing
    assign sleep_abort = (state_r == ST_ENTERING) && abort_on_weak_battery_r
                         && battery_low_detect_en_r && batt_low_s; // (RULE9)
    assign rouse = (state_r == ST_ASLEEP)
                   && ((pin_rouse_en_r && !wake_n_s)
                       || (rtc_rouse_en_r && (hit_a || hit_b))); // (RULE2) (RULE19) (RULE13)

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_AWAKE: begin
                if (sleep_request_r) begin
                    state_nxt = ST_ENTERING; // (RULE17)
                end
            end
            ST_ENTERING: begin
                state_nxt = sleep_abort ? ST_AWAKE : ST_ASLEEP;
            end
            ST_ASLEEP: begin
                if (rouse) begin
                    state_nxt = ST_AWAKE; // (RULE2)
                end
            end
            default: begin
                state_nxt = ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_AWAKE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Raw status survives the wake
    always_ff @(posedge clk) begin
        if (reset) begin
            regulator_off_n_r <= 1'b1;
        end else begin
            regulator_off_n_r <= (state_nxt != ST_ASLEEP); // (RULE1) (RULE20)
        end
    end

    // Read data is captured in the setup cycle, ready in the access cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
            if (is_mem(paddr)) begin
                if (rd_setup) begin
                    prdata_r <= retained_memory_r[mem_index(paddr)]; // (RULE16)
                end
            end else begin
                unique case (paddr)
                    ADDR_RTC_COUNT: prdata_r <= rd_setup ? rtc_count_r : '0;
                    ADDR_MATCH_A:   prdata_r <= rd_setup ? rtc_match_a_r : '0;
                    ADDR_MATCH_B:   prdata_r <= rd_setup ? rtc_match_b_r : '0;
                    ADDR_LOAD:      prdata_r <= rd_setup ? rtc_load_value_r : '0;
                    ADDR_CONTROL: begin
                        if (rd_setup) begin
                            prdata_r[CTL_RTC_RUN]     <= rtc_run_en_r;
                            prdata_r[CTL_SLEEP_REQ]   <= sleep_request_r;
                            prdata_r[CTL_SRC_SEL]     <= osc_source_select_r;
                            prdata_r[CTL_RTC_ROUSE]   <= rtc_rouse_en_r;
                            prdata_r[CTL_PIN_ROUSE]   <= pin_rouse_en_r;
                            prdata_r[CTL_BATT_DETECT] <= battery_low_detect_en_r;
                            prdata_r[CTL_OSC_ENABLE]  <= osc_enable_r;
                            prdata_r[CTL_BATT_ABORT]  <= abort_on_weak_battery_r;
                        end
                    end
                    ADDR_MASK:    prdata_r[EV_WIDTH-1:0] <= rd_setup ? event_mask_r : '0;
                    ADDR_RAW:     prdata_r[EV_WIDTH-1:0] <= rd_setup ? raw_event_status_r : '0;
                    ADDR_MASKED:  prdata_r[EV_WIDTH-1:0] <= rd_setup ? masked : '0;
                    ADDR_CLEAR:   prdata_r <= '0;
                    ADDR_TRIM:    prdata_r[15:0] <= rd_setup ? rtc_predivider_trim_r : '0;
                    default:      pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    assign prdata          = prdata_r;
    assign pslverr         = pslverr_r;
    assign irq             = irq_r;
    assign regulator_off_n = regulator_off_n_r;
endmodule
`default_nettype wire

// ### hw/hib_pkg.sv
// Constants shared by the hibernation controller and its helpers.
// Assumes a single 125 MHz system clock and a 32-bit APB register bus.
package hib_pkg;

    // Register byte offsets
    localparam logic [11:0] ADDR_RTC_COUNT   = 12'h000;
    localparam logic [11:0] ADDR_MATCH_A     = 12'h004;
    localparam logic [11:0] ADDR_MATCH_B     = 12'h008;
    localparam logic [11:0] ADDR_LOAD        = 12'h00c;
    localparam logic [11:0] ADDR_CONTROL     = 12'h010;
    localparam logic [11:0] ADDR_MASK        = 12'h014;
    localparam logic [11:0] ADDR_RAW         = 12'h018;
    localparam logic [11:0] ADDR_MASKED      = 12'h01c;
    localparam logic [11:0] ADDR_CLEAR       = 12'h020;
    localparam logic [11:0] ADDR_TRIM        = 12'h024;
    localparam logic [11:0] ADDR_MEM_FIRST   = 12'h030;
    localparam logic [11:0] ADDR_MEM_LAST    = 12'h12c;

    // Control register bit positions
    localparam int CTL_RTC_RUN     = 0;
    localparam int CTL_SLEEP_REQ   = 1;
    localparam int CTL_SRC_SEL     = 2;
    localparam int CTL_RTC_ROUSE   = 3;
    localparam int CTL_PIN_ROUSE   = 4;
    localparam int CTL_BATT_DETECT = 5;
    localparam int CTL_OSC_ENABLE  = 6;
    localparam int CTL_BATT_ABORT  = 7;

    // Event bit positions in raw, mask, masked and clear registers
    localparam int EV_MATCH_A  = 0;
    localparam int EV_MATCH_B  = 1;
    localparam int EV_BATT_LOW = 2;
    localparam int EV_PIN_WAKE = 3;
    localparam int EV_WIDTH    = 4;

    // Reset values
    localparam logic [31:0] MATCH_RESET = 32'hffffffff;
    localparam logic [31:0] LOAD_RESET  = 32'hffffffff;
    localparam logic [15:0] TRIM_NOMINAL = 16'h7fff;

    // Clocking of the slow reference
    localparam logic [6:0] XTAL_DIV_LAST = 7'h7f;   // Divide by 128
    localparam logic [5:0] TRIM_SEC_LAST = 6'h3f;   // One second in 64

    // Retained memory
    localparam int MEM_WORDS = 64;
    localparam int MEM_IDX_W = 6;

    typedef enum logic [2:0] {
        ST_AWAKE    = 3'b001,
        ST_ENTERING = 3'b010,
        ST_ASLEEP   = 3'b100
    } power_state_t;

endpackage

// ### hw/pin_sync.sv
// Three-stage synchroniser for a pin that is asynchronous to clk.
// The output moves only once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pin and synchronised level
    input  wire logic pin,
    output logic      level
);
    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic level_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_r <= RESET_VALUE;
            stage2_r <= RESET_VALUE;
            stage3_r <= RESET_VALUE;
        end else begin
            stage1_r <= pin;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // A single disagreeing sample is treated as a glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            level_r <= RESET_VALUE;
        end else if (stage2_r == stage3_r) begin
            level_r <= stage3_r;
        end
    end

    assign level = level_r;
endmodule
`default_nettype wire

// ### hw/rtc_predivider.sv
// Predivider forming the one-second tick from reference ticks.
// Assumes ref_tick is a one-cycle pulse per 32.768 kHz period.
`timescale 1ns/1ns
`default_nettype none
module rtc_predivider
    import hib_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Control
    input  wire logic        run,
    input  wire logic        ref_tick,
    input  wire logic [15:0] trim,
    // Second tick
    output logic             sec_tick
);
    logic [15:0] count_r;
    logic [5:0]  sec_idx_r;
    logic        sec_tick_r;
    logic [15:0] divisor;

    // The trimmed divisor applies to the last second of every 64
    assign divisor = (sec_idx_r + 6'h01 == TRIM_SEC_LAST) ? trim : TRIM_NOMINAL; // (RULE11) (RULE12)

    always_ff @(posedge clk) begin
        if (reset) begin
            count_r    <= TRIM_NOMINAL;
            sec_idx_r  <= '0;
            sec_tick_r <= 1'b0;
        end else begin
            sec_tick_r <= 1'b0;
            if (!run) begin
                count_r   <= TRIM_NOMINAL;
                sec_idx_r <= '0;
            end else if (ref_tick) begin
                // Period is divisor + 1 reference ticks
                if (count_r == 16'h0000) begin // (RULE11)
                    sec_tick_r <= 1'b1;
                    sec_idx_r  <= sec_idx_r + 6'h01;
                    count_r    <= divisor;
                end else begin
                    count_r <= count_r - 16'h0001;
                end
            end
        end
    end

    assign sec_tick = sec_tick_r;
endmodule
`default_nettype wire

// ### verification/hib_chk.sv
// Checker on the controller's ports.
// Assumes one clock and a synchronous high reset.
`timescale 1ns/1ns
`default_nettype none
module hib_chk
    import hib_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        wake_n,
    input wire logic        battery_low_in,
    input wire logic        regulator_off_n,
    input wire logic        irq
);
    logic [7:0] ctl_r;
    wire        wr = psel && penable && pwrite;
    wire        setup = psel && !penable;
    wire        bad = (|paddr[1:0]) || (paddr[11:3] == 9'h005) || (paddr > ADDR_MEM_LAST);
    // Last control write; wake enables survive sleep
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_r <= 8'h00;
        end else if (wr && paddr == ADDR_CONTROL) begin
            ctl_r <= pwdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence sleep_wr;
        wr && paddr == ADDR_CONTROL && pwdata[CTL_SLEEP_REQ];
    endsequence
    sequence pin_held;
        !wake_n [*6];
    endsequence
    sequence batt_weak;
        battery_low_in [*6];
    endsequence
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_sleep_entry: assert property (sleep_wr ##0 (regulator_off_n && !pwdata[CTL_BATT_ABORT])
        |-> ##[1:3] !regulator_off_n) else $error("sleep not entered");
    chk_abort_hold: assert property (batt_weak ##0 sleep_wr ##0 (pwdata[CTL_BATT_ABORT]
        && pwdata[CTL_BATT_DETECT]) |=> regulator_off_n [*4]) else $error("sleep despite weak battery");
    chk_pin_wake: assert property (!regulator_off_n && ctl_r[CTL_PIN_ROUSE] ##0 pin_held
        |-> ##[0:3] regulator_off_n) else $error("no wake on pin");
    chk_no_rouse: assert property (!regulator_off_n && !ctl_r[CTL_PIN_ROUSE] && !ctl_r[CTL_RTC_RUN]
        |=> !regulator_off_n) else $error("wake without source");
    chk_bus_error: assert property (setup |=> pslverr == $past(bad) && (!pslverr || prdata == 32'h0))
        else $error("pslverr wrong");
    chk_load_count: assert property (wr && paddr == ADDR_LOAD ##2 setup && !pwrite && paddr == ADDR_RTC_COUNT
        |=> prdata == $past(pwdata, 3)) else $error("load not seen");
    chk_mask_off: assert property (wr && paddr == ADDR_MASK && pwdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("irq despite mask");
    chk_reset_idle: assert property ($fell(reset) |-> regulator_off_n && !irq && !pslverr)
        else $error("bad state after reset");
endmodule
bind hibernate_power_rtc_controller hib_chk i_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wake_n, .battery_low_in, .regulator_off_n, .irq);
`default_nettype wire

// ### verification/wake_regulator_model.sv
// Regulator, wake switch and slow oscillator.
// Assumes the bench clock; press comes from the bench.
`timescale 1ns/1ns
`default_nettype none
module wake_regulator_model (
    // Clock
    input  wire logic clk,
    // Device side
    input  wire logic regulator_off_n,
    output logic      wake_n,
    output logic      osc_clk,
    // Bench side
    input  wire logic press,
    output logic      supply_on
);
    logic [2:0] div_r = 3'h0;
    // Pulled up: released switch reads high
    assign wake_n = !press;
    assign supply_on = regulator_off_n;
    // Four clocks per phase keeps each level past the synchroniser
    assign osc_clk = div_r[2];
    always @(posedge clk) begin
        div_r <= div_r + 3'h1;
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Bench for the hibernation controller.
// Assumes the bound checker and the pin model.
`timescale 1ns/1ns
`default_nettype none
module automatic testbench
    import hib_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        batt = 1'b0;
    logic        press = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        osc;
    logic        wake_n;
    logic        regulator_off_n;
    logic        irq;
    logic        supply_on;
    int          fails = 0;
    int          checked = 0;
    always #4 clk = !clk;
    hibernate_power_rtc_controller i_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .osc_clk_in(osc), .xtal_clk_in(osc), .wake_n, .battery_low_in(batt),
        .regulator_off_n, .irq);
    wake_regulator_model i_far (.clk, .regulator_off_n, .wake_n, .osc_clk(osc), .press, .supply_on);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Entered right after an edge; leaves one idle cycle behind
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task expect_rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task do_reset;
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    task t_regs;
        expect_rd(ADDR_MATCH_A, MATCH_RESET);
        expect_rd(ADDR_LOAD, LOAD_RESET);
        expect_rd(ADDR_TRIM, 32'h7fff);
        apb(1'b1, ADDR_TRIM, 32'h8000);
        expect_rd(ADDR_TRIM, 32'h8000);
        apb(1'b1, ADDR_MATCH_B, 32'h55);
        expect_rd(ADDR_MATCH_B, 32'h55);
        apb(1'b1, ADDR_RTC_COUNT, 32'h5);
        expect_rd(ADDR_RTC_COUNT, 32'h0);
        apb(1'b1, ADDR_MEM_FIRST, 32'ha5a50001);
        expect_rd(ADDR_MEM_FIRST, 32'ha5a50001);
        expect_rd(12'h130, 32'h0);
        check({31'h0, pslverr}, 32'h1);
        apb(1'b1, ADDR_LOAD, 32'h12345678);
        expect_rd(ADDR_RTC_COUNT, 32'h12345678);
    endtask
    task t_battery;
        batt <= 1'b1;
        apb(1'b1, ADDR_CONTROL, 32'h60);
        repeat (8) @(posedge clk);
        expect_rd(ADDR_RAW, 32'h4);
        apb(1'b1, ADDR_MASK, 32'h0);
        expect_rd(ADDR_MASKED, 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h4);
        expect_rd(ADDR_MASKED, 32'h4);
        check({31'h0, irq}, 32'h1);
        batt <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_CLEAR, 32'h4);
        expect_rd(ADDR_RAW, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask
    task t_abort;
        batt <= 1'b1;
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_CONTROL, 32'hf2);
        repeat (6) @(posedge clk);
        check({31'h0, supply_on}, 32'h1);
        expect_rd(ADDR_CONTROL, 32'hf0);
        batt <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_CLEAR, 32'hf);
    endtask
    task t_pin_sleep;
        apb(1'b1, ADDR_MEM_LAST, 32'h5a5a003f);
        apb(1'b1, ADDR_CONTROL, 32'h56);
        repeat (4) @(posedge clk);
        check({31'h0, supply_on}, 32'h0);
        press <= 1'b1;
        repeat (10) @(posedge clk);
        check({31'h0, supply_on}, 32'h1);
        expect_rd(ADDR_RAW, 32'h8);
        expect_rd(ADDR_CONTROL, 32'h54);
        expect_rd(ADDR_MEM_LAST, 32'h5a5a003f);
        press <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task t_rtc_only;
        apb(1'b1, ADDR_CLEAR, 32'hf);
        apb(1'b1, ADDR_CONTROL, 32'h4a);
        press <= 1'b1;
        repeat (12) @(posedge clk);
        check({31'h0, supply_on}, 32'h0);
        press <= 1'b0;
        do_reset;
        check({31'h0, supply_on}, 32'h1);
    endtask
    task report_and_stop;
        $display("Checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        do_reset;
        t_regs;
        t_battery;
        t_abort;
        t_pin_sleep;
        t_rtc_only;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop;
    end
endmodule
`default_nettype wire
